/* File: rtl/fgs_supervisor.sv */
// Fieldbus gateway fault supervisor: data FIFO and supervisor top module.
`timescale 1ns/1ns

// ------------------------------------------------------------
// Process data FIFO
// ------------------------------------------------------------
module fgs_fifo #(
	parameter int unsigned W     = 17,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             cnt;
		logic                    room;
		logic                    avail;
	} fgs_fifo_st_t;

	fgs_fifo_st_t s;
	fgs_fifo_st_t next_s;
	logic         push;
	logic         pop;

	// Pointer, count and flag update; full and empty are kept as flops.
	always_comb begin
		next_s = s;
		push   = in_valid & s.room;
		pop    = out_ready & s.avail;
		if (push) begin
			next_s.mem[s.wr] = in_data;
			next_s.wr        = s.wr + 1'b1;
		end
		if (pop) begin
			next_s.rd = s.rd + 1'b1;
		end
		next_s.cnt   = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		next_s.room  = next_s.cnt != (AW+1)'(DEPTH);
		next_s.avail = next_s.cnt != '0;
	end

	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s      <= '0;
			s.room <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign in_ready  = s.room;
	assign out_valid = s.avail;
	assign out_data  = s.mem[s.rd];

endmodule // fgs_fifo

// ------------------------------------------------------------
// Supervisor top
// ------------------------------------------------------------
module fgs_supervisor import fgs_pkg::*; #(
	parameter int unsigned CYC_MS = CYC_PER_MS
) (
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// Fieldbus process output stream
	input  wire logic               fb_valid,
	output logic                    fb_ready,
	input  wire fgs_pd_word_t       fb_word,
	// Connection object attribute writes
	input  wire logic               epr_wr,
	input  wire logic [7:0]         epr_class,
	input  wire logic [7:0]         epr_attr,
	input  wire logic [15:0]        epr_ms,
	output logic                    epr_reject,
	// Configuration
	input  wire logic               timeout_response_param,
	input  wire logic [1:0]         pd_words,
	input  wire logic               configured,
	input  wire logic               maint_off,
	// Digital outputs
	input  wire logic [7:0]         dout_req,
	output logic [7:0]              dout,
	// Drive sub-bus stream and liveness
	output logic                    drv_valid,
	input  wire logic               drv_ready,
	output fgs_pd_word_t            drv_word,
	input  wire logic [NDRV-1:0]    drv_alive,
	input  wire logic [NDRV-1:0]    drv_present,
	// Hardware defects
	input  wire logic               hw_defect,
	input  wire logic [7:0]         hw_code,
	output logic                    inhibit,
	// Status and diagnostics
	output logic                    system_fault_indicator,
	output logic [15:0]             status_word1,
	output logic [7:0]              diag_code,
	output logic                    fb_timeout,
	input  wire logic               read_system_error_cmd,
	output logic                    sys_err_valid,
	output logic [7:0]              sys_err_code
);

	typedef struct packed {
		logic [DIV_W-1:0]             div;
		logic [15:0]                  epr;
		logic [TMO_W-1:0]             tmo_cnt;
		logic                         fb_tmo;
		logic                         force_pend;
		logic [1:0]                   idx;
		logic                         out_valid;
		fgs_pd_word_t                 out_word;
		logic [7:0]                   dout;
		logic [NDRV-1:0][MSC_W-1:0]   drv_cnt;
		logic [NDRV-1:0]              lost;
		logic [MSC_W-1:0]             blink_cnt;
		logic                         blink;
		logic                         led;
		logic [15:0]                  status_word1;
		logic [7:0]                   diag_code;
		logic                         inhibit;
		logic                         epr_reject;
		logic                         sys_err_valid;
		logic [7:0]                   sys_err_code;
	} fgs_state_t;

	fgs_state_t       s;
	fgs_state_t       next_s;
	logic [1:0]       rst_sync;
	logic             rst_q_n;
	logic             tick;
	logic             msg;
	logic [TMO_W-1:0] limit;
	logic             force_c;
	logic             flash_c;
	logic             steady_c;
	logic             rs485_c;
	logic             fifo_valid;
	logic             fifo_pop;
	fgs_pd_word_t     fifo_word;

	// Checks a packet rate value for the 5 ms granularity.
	function automatic logic epr_ok(input logic [15:0] v);
		epr_ok = (v % EPR_STEP_MS) == 16'h0000;
	endfunction

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------

	// Two-flop release of the asynchronous reset.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_q_n = rst_sync[1];

	// ------------------------------------------------------------
	// Buffer between fieldbus and drive sub-bus
	// ------------------------------------------------------------
	fgs_fifo #(
		.W     (PD_WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_q_n),
		.in_valid  (fb_valid),
		.in_ready  (fb_ready),
		.in_data   (fb_word),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_word)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Time base, supervision, forced output, drive liveness and indication.
	always_comb begin
		next_s   = s;
		fifo_pop = 1'b0;
		tick     = s.div == DIV_W'(CYC_MS - 1);
		next_s.div = tick ? '0 : s.div + 1'b1;
		msg      = fb_valid & fb_ready & fb_word.last;
		limit    = {s.epr, 2'b00};
		next_s.epr_reject = 1'b0;
		// Attribute write of the expected packet rate.
		if (epr_wr && epr_class == EPR_CLASS && epr_attr == EPR_ATTR) begin
			if (epr_ok(epr_ms)) begin
				next_s.epr     = epr_ms;
				next_s.tmo_cnt = '0;
			end else begin
				next_s.epr_reject = 1'b1;
			end
		end
		// Timeout counting in milliseconds since the last complete message.
		if (msg) begin
			next_s.tmo_cnt = '0;
			next_s.fb_tmo  = 1'b0;
		end else if (tick && s.epr != EPR_RESET && !s.fb_tmo) begin
			if (s.tmo_cnt == limit - 1'b1) begin
				next_s.fb_tmo = 1'b1;
			end else begin
				next_s.tmo_cnt = s.tmo_cnt + 1'b1;
			end
		end
		if (s.epr == EPR_RESET) begin
			next_s.fb_tmo = 1'b0;
		end
		force_c = (s.fb_tmo & timeout_response_param) | hw_defect;
		// Output register toward the drives.
		if (!s.out_valid || drv_ready) begin
			next_s.out_valid = 1'b0;
			if (force_c) begin
				fifo_pop = fifo_valid;
				if (s.force_pend && pd_words != 2'h0) begin
					next_s.out_valid     = 1'b1;
					next_s.out_word.last = s.idx == pd_words - 1'b1;
					next_s.idx           = next_s.out_word.last ? 2'h0 : s.idx + 1'b1;
					next_s.force_pend    = !next_s.out_word.last;
				end
			end else if (fifo_valid) begin
				next_s.out_valid = 1'b1;
				next_s.out_word  = fifo_word;
				fifo_pop         = 1'b1;
			end
		end
		// Every forced word, a word held at the output included, is zero.
		if (force_c) begin
			next_s.out_word.data = '0;
			if (tick) begin
				next_s.force_pend = 1'b1;
			end
		end else begin
			next_s.force_pend = 1'b0;
			next_s.idx        = 2'h0;
		end
		next_s.dout = force_c ? 8'h00 : dout_req;
		// Per-drive silence counters.
		for (int i = 0; i < NDRV; i++) begin
			if (drv_alive[i]) begin
				next_s.drv_cnt[i] = '0;
				next_s.lost[i]    = 1'b0;
			end else if (tick && !s.lost[i]) begin
				if (s.drv_cnt[i] == DRV_TMO_MS - 1'b1) begin
					next_s.lost[i] = 1'b1;
				end else begin
					next_s.drv_cnt[i] = s.drv_cnt[i] + 1'b1;
				end
			end
		end
		rs485_c = |(s.lost & drv_present);
		// Status word and diagnostic code.
		next_s.status_word1 = (rs485_c | hw_defect) ? ERR_SYSTEM : 16'h0000;
		if (hw_defect) begin
			next_s.diag_code = hw_code;
		end else if (rs485_c) begin
			next_s.diag_code = ERR_SYSTEM[7:0];
		end else if (s.fb_tmo) begin
			next_s.diag_code = ERR_FB_TMO;
		end else begin
			next_s.diag_code = ERR_NONE;
		end
		next_s.inhibit = hw_defect;
		// System read command returns the exact code one cycle later.
		next_s.sys_err_valid = read_system_error_cmd;
		if (read_system_error_cmd) begin
			next_s.sys_err_code = next_s.diag_code;
		end
		// Blink phase and indicator selection; flashing takes precedence.
		if (tick) begin
			if (s.blink_cnt == BLINK_MS - 1'b1) begin
				next_s.blink_cnt = '0;
				next_s.blink     = ~s.blink;
			end else begin
				next_s.blink_cnt = s.blink_cnt + 1'b1;
			end
		end
		flash_c  = hw_defect | (s.fb_tmo & timeout_response_param);
		steady_c = !configured | rs485_c | maint_off;
		next_s.led = flash_c ? s.blink : steady_c;
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register.
	assign epr_reject             = s.epr_reject;
	assign dout                   = s.dout;
	assign drv_valid              = s.out_valid;
	assign drv_word               = s.out_word;
	assign inhibit                = s.inhibit;
	assign system_fault_indicator = s.led;
	assign status_word1           = s.status_word1;
	assign diag_code              = s.diag_code;
	assign fb_timeout             = s.fb_tmo;
	assign sys_err_valid          = s.sys_err_valid;
	assign sys_err_code           = s.sys_err_code;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_q_n);

	sequence s_forced;
		force_c ##1 force_c;
	endsequence

	sequence s_expire;
		tick && !msg && !s.fb_tmo && s.epr != EPR_RESET && s.tmo_cnt == limit - 1'b1;
	endsequence

	a_led_dark_normal: assert property (!flash_c && !steady_c |=> !system_fault_indicator)
		else $error("indicator lit in normal operation");
	a_led_flash_fault: assert property (flash_c |=> system_fault_indicator == $past(s.blink))
		else $error("indicator not following blink phase in fault");
	a_led_steady_cfg: assert property (!flash_c && !configured |=> system_fault_indicator)
		else $error("indicator dark while unconfigured");
	a_led_maint_off: assert property (!flash_c && maint_off |=> system_fault_indicator)
		else $error("indicator dark with maintenance switch off");
	a_zero_words: assert property (s_forced |-> !drv_valid || drv_word.data == 16'h0000)
		else $error("nonzero word sent while forced");
	a_dout_zero: assert property (force_c |=> dout == 8'h00)
		else $error("digital outputs not zero while forced");
	a_tmo_expire_set: assert property (s_expire |=> fb_timeout)
		else $error("fieldbus timeout not declared at interval end");
	a_tmo_msg_clear: assert property (msg |=> !fb_timeout ##1 (!fb_timeout || $past(tick)))
		else $error("fieldbus timeout not cleared by message");
	a_status_code: assert property ((rs485_c || hw_defect) |=> status_word1 == 16'h005B)
		else $error("status word one lacks code 91");
	a_epr_bad_step: assert property (epr_wr && epr_class == EPR_CLASS
		&& epr_attr == EPR_ATTR && !epr_ok(epr_ms) |=> epr_reject && $stable(s.epr))
		else $error("illegal packet rate accepted");
	a_hw_inhibit: assert property (hw_defect |=> inhibit && status_word1 == ERR_SYSTEM)
		else $error("hardware defect did not inhibit");
	a_drv_recover: assert property (drv_alive[0] |=> !s.lost[0])
		else $error("drive timeout not cleared on answer");

endmodule // fgs_supervisor

/* File: inc/fgs_pkg.sv */
// Shared constants and carrier types of the fieldbus gateway fault supervisor.
package fgs_pkg;

	// ------------------------------------------------------------
	// Clock and time base
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned DIV_W         = 15;

	// ------------------------------------------------------------
	// Fieldbus timeout supervision
	// ------------------------------------------------------------
	localparam logic [7:0]  EPR_CLASS   = 8'h05;
	localparam logic [7:0]  EPR_ATTR    = 8'h09;
	localparam logic [15:0] EPR_STEP_MS = 16'h0005;
	localparam logic [15:0] EPR_RESET   = 16'h0000;
	localparam int unsigned TMO_SHIFT   = 2;
	localparam int unsigned TMO_W       = 18;

	// ------------------------------------------------------------
	// Drive sub-bus supervision and indicator timing
	// ------------------------------------------------------------
	localparam int unsigned NDRV        = 4;
	localparam int unsigned MSC_W       = 10;
	localparam logic [9:0]  DRV_TMO_MS  = 10'h3E8;
	localparam logic [9:0]  BLINK_MS    = 10'h1F4;

	// ------------------------------------------------------------
	// Error codes
	// ------------------------------------------------------------
	localparam logic [15:0] ERR_SYSTEM  = 16'h005B;
	localparam logic [7:0]  ERR_FB_TMO  = 8'h1C;
	localparam logic [7:0]  ERR_NONE    = 8'h00;

	// ------------------------------------------------------------
	// Data path
	// ------------------------------------------------------------
	localparam int unsigned PD_W        = 16;
	localparam int unsigned FIFO_DEPTH  = 32;

	typedef struct packed {
		logic [PD_W-1:0] data;
		logic            last;
	} fgs_pd_word_t;

	localparam int unsigned PD_WORD_W = $bits(fgs_pd_word_t);

endpackage

/* File: verification/fgs_drive_model.sv */
// Behavioural drive inverters on the sub-bus side of the fault supervisor.
`timescale 1ns/1ns

module fgs_drive_model import fgs_pkg::*; #(
	parameter int unsigned STOP_CYC = 4000
) (
	// Clock
	input  wire logic            clk,
	// Sub-bus stream
	input  wire logic            drv_valid,
	output logic                 drv_ready,
	input  wire fgs_pd_word_t    drv_word,
	output logic [NDRV-1:0]      drv_alive,
	// Test control and drive state
	input  wire logic            stall,
	input  wire logic [NDRV-1:0] mute,
	output logic                 stopped
);
	fgs_pd_word_t rx_q[$];
	int unsigned  idle = 0;
	int unsigned  tick = 0;

	// Ready and answers change off the sampling edge; muted drives stay silent.
	always @(negedge clk) begin
		tick      <= tick + 1;
		drv_ready <= !stall;
		drv_alive <= (tick % 16 == 0) ? ~mute : '0;
	end

	// Words are taken on the rising edge; a starved drive stops by itself.
	always @(posedge clk) begin
		if (drv_valid && drv_ready) begin
			rx_q.push_back(drv_word);
			idle = 0;
		end else begin
			idle = idle + 1;
		end
		stopped <= (idle >= STOP_CYC);
	end
endmodule // fgs_drive_model

/* File: verification/fgs_supervisor_tb.sv */
// Self-checking testbench of the fieldbus gateway fault supervisor.
`timescale 1ns/1ns

module fgs_supervisor_tb import fgs_pkg::*;;
	localparam int unsigned CMS = 4;
	logic ref_clk, rst_n, fb_valid, fb_ready, epr_wr, epr_reject, timeout_response_param;
	logic configured, maint_off, drv_valid, drv_ready, hw_defect, inhibit, stall, stopped;
	logic system_fault_indicator, fb_timeout, read_system_error_cmd, sys_err_valid;
	logic [7:0]      epr_class, epr_attr, dout_req, dout, hw_code, diag_code, sys_err_code;
	logic [15:0]     epr_ms, status_word1;
	logic [1:0]      pd_words;
	logic [NDRV-1:0] drv_alive, drv_present, mute;
	fgs_pd_word_t    fb_word, drv_word;
	int              miscompares, n_checks;

	// ------------------------------------------------------------
	// Design and partner
	// ------------------------------------------------------------
	fgs_supervisor #(.CYC_MS(CMS)) u_fgs_supervisor (.ref_clk, .rst_n, .fb_valid, .fb_ready,
		.fb_word, .epr_wr, .epr_class, .epr_attr, .epr_ms, .epr_reject, .timeout_response_param,
		.pd_words, .configured, .maint_off, .dout_req, .dout, .drv_valid, .drv_ready, .drv_word,
		.drv_alive, .drv_present, .hw_defect, .hw_code, .inhibit, .system_fault_indicator,
		.status_word1, .diag_code, .fb_timeout, .read_system_error_cmd, .sys_err_valid,
		.sys_err_code);
	fgs_drive_model #(.STOP_CYC(1000 * CMS)) u_fgs_drive_model (.clk(ref_clk), .drv_valid,
		.drv_ready, .drv_word, .drv_alive, .stall, .mute, .stopped);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic complete_run();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic epr_write(input logic [7:0] c, input logic [7:0] a, input logic [15:0] ms,
		input logic rej);
		logic r;
		@(negedge ref_clk);
		{epr_wr, epr_class, epr_attr, epr_ms} = {1'b1, c, a, ms};
		cyc(1);
		epr_wr = 1'b0;
		r = epr_reject;
		cyc(1);
		chk(r, rej);
		chk(epr_reject, 0);
	endtask
	task automatic send(input logic [15:0] d);
		int k;
		@(negedge ref_clk);
		fb_valid = 1'b1;
		fb_word  = '{data: d, last: 1'b1};
		for (k = 0; k < 100 && fb_ready !== 1'b1; k++) cyc(1);
		chk(fb_ready, 1);
		cyc(1);
		fb_valid = 1'b0;
	endtask
	task automatic read_err(input logic [7:0] code);
		logic v;
		@(negedge ref_clk);
		read_system_error_cmd = 1'b1;
		cyc(1);
		read_system_error_cmd = 1'b0;
		v = sys_err_valid;
		cyc(1);
		chk(v, 1);
		chk(sys_err_valid, 0);
		chk(sys_err_code, code);
	endtask
	task automatic saw_flash();
		logic s0, s1;
		{s0, s1} = 2'b00;
		repeat (1100 * CMS) begin
			cyc(1);
			s0 |= (system_fault_indicator === 1'b0);
			s1 |= (system_fault_indicator === 1'b1);
		end
		chk({s0, s1}, 2'b11);
	endtask
	// Collects forced frames and checks zero data and a last flag every n words.
	task automatic frames(input int n);
		int j;
		u_fgs_drive_model.rx_q.delete();
		cyc(40);
		j = 0;
		while (j < u_fgs_drive_model.rx_q.size() && !u_fgs_drive_model.rx_q[j].last) j++;
		chk(u_fgs_drive_model.rx_q.size() > j + 6, 1);
		for (int i = j + 1; i < u_fgs_drive_model.rx_q.size(); i++) begin
			chk(u_fgs_drive_model.rx_q[i].data, 0);
			chk(u_fgs_drive_model.rx_q[i].last, (i - j) % n == 0);
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_indicator();
		chk(system_fault_indicator, 1);
		configured = 1'b1;
		cyc(40);
		chk(system_fault_indicator, 0);
		maint_off = 1'b1;
		cyc(3);
		chk(system_fault_indicator, 1);
		maint_off = 1'b0;
		dout_req  = 8'hA5;
		cyc(3);
		chk(system_fault_indicator, 0);
		chk(dout, 8'hA5);
	endtask
	task automatic t_fifo();
		int n;
		logic rp;
		stall = 1'b1;
		n = 0;
		@(negedge ref_clk);
		fb_valid = 1'b1;
		fb_word  = '{data: 16'h0000, last: 1'b1};
		rp = fb_ready;
		repeat (60) begin
			cyc(1);
			n += rp;
			fb_word.data = 16'(n);
			rp = fb_ready;
		end
		fb_valid = 1'b0;
		chk(n == FIFO_DEPTH + 1, 1);
		chk(fb_ready, 0);
		stall = 1'b0;
		cyc(120);
		chk(u_fgs_drive_model.rx_q.size(), n);
		foreach (u_fgs_drive_model.rx_q[i]) chk(u_fgs_drive_model.rx_q[i].data, i);
	endtask
	task automatic t_timeout();
		int k;
		pd_words = 2'h3;
		epr_write(8'h05, 8'h09, 16'h0007, 1'b1);
		epr_write(8'h06, 8'h09, 16'h0007, 1'b0);
		epr_write(8'h05, 8'h09, 16'h0005, 1'b0);
		for (k = 0; k < 300 && fb_timeout !== 1'b1; k++) cyc(1);
		chk(k >= 4 * 5 * CMS - 8 && k <= 4 * 5 * CMS + 12, 1);
		cyc(3);
		chk(dout, 8'h00);
		chk(diag_code, ERR_FB_TMO);
		read_err(ERR_FB_TMO);
		frames(3);
		saw_flash();
		send(16'h0BEE);
		cyc(3);
		chk(fb_timeout, 0);
		chk(dout, 8'hA5);
		cyc(10);
		u_fgs_drive_model.rx_q.delete();
		send(16'h0C0D);
		cyc(10);
		chk(u_fgs_drive_model.rx_q.size(), 1);
		if (u_fgs_drive_model.rx_q.size() > 0) chk(u_fgs_drive_model.rx_q[0].data, 16'h0C0D);
	endtask
	task automatic t_param();
		timeout_response_param = 1'b0;
		cyc(30 * CMS);
		chk(fb_timeout, 1);
		chk(dout, 8'hA5);
		chk(system_fault_indicator, 0);
		epr_write(8'h05, 8'h09, 16'h0000, 1'b0);
		cyc(3);
		chk(fb_timeout, 0);
		timeout_response_param = 1'b1;
	endtask
	task automatic t_drive_lost();
		int k;
		mute = 4'h4;
		for (k = 0; k < 1100 * CMS && status_word1 !== ERR_SYSTEM; k++) cyc(1);
		chk(k >= 990 * CMS && k <= 1010 * CMS, 1);
		cyc(10);
		chk(status_word1, ERR_SYSTEM);
		chk(system_fault_indicator, 1);
		chk(diag_code, 8'h5B);
		chk(stopped, 1);
		mute = 4'h0;
		cyc(40);
		chk(status_word1, 16'h0000);
		chk(system_fault_indicator, 0);
	endtask
	task automatic t_hw();
		hw_code   = 8'h33;
		hw_defect = 1'b1;
		pd_words  = 2'h2;
		cyc(3);
		chk(inhibit, 1);
		chk(status_word1, ERR_SYSTEM);
		chk(diag_code, 8'h33);
		read_err(8'h33);
		frames(2);
		chk(stopped, 0);
		saw_flash();
		hw_defect = 1'b0;
		cyc(3);
		chk(inhibit, 0);
	endtask

	// ------------------------------------------------------------
	// Clock, sequence and watchdog
	// ------------------------------------------------------------
	// Free-running reference clock at 25 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Main sequence: every input starts defined, reset is held four cycles.
	initial begin
		{rst_n, fb_valid, epr_wr, configured, maint_off, hw_defect, stall} = '0;
		{read_system_error_cmd, epr_class, epr_attr, epr_ms, dout_req, hw_code} = '0;
		{mute, pd_words, fb_word} = '0;
		timeout_response_param = 1'b1;
		drv_present = 4'hF;
		{miscompares, n_checks} = '0;
		cyc(4);
		rst_n = 1'b1;
		cyc(4);
		t_indicator();
		t_fifo();
		t_timeout();
		t_param();
		t_drive_lost();
		t_hw();
		complete_run();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#(40 * 40000);
		miscompares++;
		complete_run();
	end
endmodule // fgs_supervisor_tb
